// *** pkg/tmr_pkg.sv ***
package tmr_pkg;
  // register byte addresses on the apb bus
  localparam logic [11:0] ADDR_CONTROL  = 12'h000;
  localparam logic [11:0] ADDR_LOW      = 12'h004;
  localparam logic [11:0] ADDR_HIGH     = 12'h008;
  localparam logic [11:0] ADDR_IRQ_CTRL = 12'h00c;
  localparam logic [11:0] ADDR_STATUS   = 12'h010;
  localparam logic [11:0] ADDR_MASK     = 12'h014;
  localparam logic [11:0] ADDR_SLEEP    = 12'h018;

  // timer_control fields
  localparam int BIT_ON     = 7;
  localparam int BIT_WIDTH8 = 6;
  localparam int BIT_SRC    = 5;
  localparam int BIT_EDGE   = 4;
  localparam int BIT_BYPASS = 3;
  localparam int PS_LSB     = 0;
  localparam int PS_W       = 3;

  // interrupt_control fields
  localparam int BIT_IRQ_EN = 5;
  localparam int BIT_OVF    = 2;

  // status / mask layout
  localparam int ST_OVF  = 0;
  localparam int ST_WRAP = 1;
  localparam int ST_W    = 2;

  localparam logic [7:0] CONTROL_RESET = 8'hff;
  localparam logic [7:0] HIGH_RESET    = 8'h00;
  localparam logic [7:0] LOW_RESET     = 8'h00;

  localparam int INHIBIT_CYCLES = 2;
endpackage : tmr_pkg

// *** src/prescaled_timer.sv ***
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/10ps
// Operation
// - count_on bit lets the counter run
// - width_select set means 8-bit counting
// - clock_source_select picks count_pin or cycles
// - edge_select set counts falling pin edges
// - prescaler_bypass routes input around prescaler
// - prescale_ratio divides by two to 256
// - timer mode bypassed counts every cycle
// - counter write inhibits two following cycles
// - count_pin is synchronised before edge detection
// - prescaler count is hidden from software
// - counter write clears assigned prescaler count
// - assignment may change while running
// - wrap to zero sets overflow_flag
// - enable bit masks flag request; software clears
// - sleep stops the counter
// - low byte read captures high byte in 16-bit mode
// - low byte write loads high byte in 16-bit mode
// - high address reaches only the buffer
module prescaled_timer (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        count_pin,
  input  wire logic        sleep_req,
  output logic             irq
);

  typedef struct packed {
    logic [7:0]  control;
    logic [15:0] count;
    logic [7:0]  high_buf;
    logic        ovf;
    logic        irq_en;
    logic [tmr_pkg::ST_W-1:0] status;
    logic [tmr_pkg::ST_W-1:0] mask;
    logic        sleep_sw;
    logic [7:0]  pre;
    logic [1:0]  inhibit;
    logic        pin_s1;
    logic        pin_s2;
    logic        pin_s3;
    logic [31:0] rdata;
    logic        ready;
    logic        err;
    logic        irq;
  } state_t;

  state_t s_q;
  state_t s_d;

  // low prescaler bits that must all be ones before the next event ticks the counter
  function automatic logic [7:0] ratio_mask(input logic [2:0] code);
    logic [7:0] m;
    begin
      case (code)
        3'h0:    m = 8'h01;
        3'h1:    m = 8'h03;
        3'h2:    m = 8'h07;
        3'h3:    m = 8'h0f;
        3'h4:    m = 8'h1f;
        3'h5:    m = 8'h3f;
        3'h6:    m = 8'h7f;
        3'h7:    m = 8'hff;
        default: m = 8'hff;
      endcase
      ratio_mask = m;
    end
  endfunction : ratio_mask

  // a tick lands on every 2^(code+1)-th qualified event
  function automatic logic prescale_hit(input logic [7:0] pre, input logic [2:0] code);
    logic [7:0] m;
    begin
      m            = ratio_mask(code);
      prescale_hit = ((pre & m) == m);
    end
  endfunction : prescale_hit

  // only the two older synchroniser stages feed the detector
  function automatic logic edge_seen(input logic older, input logic newer, input logic falling);
    logic rise;
    logic fall;
    begin
      rise = !older && newer;
      fall = older && !newer;
      if (falling) begin
        edge_seen = fall;
      end else begin
        edge_seen = rise;
      end
    end
  endfunction : edge_seen

  // in 8-bit mode the high byte is frozen, so the low byte carry is dropped
  function automatic logic [15:0] bump_count(input logic [15:0] cnt, input logic eight);
    logic [7:0] lo;
    begin
      lo = cnt[7:0] + 8'h01;
      if (eight) begin
        bump_count = {cnt[15:8], lo};
      end else begin
        bump_count = cnt + 16'h0001;
      end
    end
  endfunction : bump_count

  // wrap is judged on the count before the increment
  function automatic logic wrap_seen(input logic [15:0] cnt, input logic eight);
    begin
      if (eight) begin
        wrap_seen = (cnt[7:0] == 8'hff);
      end else begin
        wrap_seen = (cnt == 16'hffff);
      end
    end
  endfunction : wrap_seen

  // the inhibit window only drains; a counter write reloads it
  function automatic logic [1:0] next_inhibit(input logic [1:0] inh);
    begin
      if (inh != 2'h0) begin
        next_inhibit = inh - 2'h1;
      end else begin
        next_inhibit = inh;
      end
    end
  endfunction : next_inhibit

  // anything off this list answers with an error and reads zero
  function automatic logic reg_mapped(input logic [11:0] addr);
    logic hit;
    begin
      case (addr)
        tmr_pkg::ADDR_CONTROL:  hit = 1'b1;
        tmr_pkg::ADDR_LOW:      hit = 1'b1;
        tmr_pkg::ADDR_HIGH:     hit = 1'b1;
        tmr_pkg::ADDR_IRQ_CTRL: hit = 1'b1;
        tmr_pkg::ADDR_STATUS:   hit = 1'b1;
        tmr_pkg::ADDR_MASK:     hit = 1'b1;
        tmr_pkg::ADDR_SLEEP:    hit = 1'b1;
        default:                hit = 1'b0;
      endcase
      reg_mapped = hit;
    end
  endfunction : reg_mapped

  // the live high byte has no read path; the high address returns the buffer
  function automatic logic [31:0] read_word(input logic [11:0] addr, input state_t st);
    logic [31:0] v;
    begin
      v = 32'h0000_0000;
      case (addr)
        tmr_pkg::ADDR_CONTROL: begin
          v[7:0] = st.control;
        end
        tmr_pkg::ADDR_LOW: begin
          v[7:0] = st.count[7:0];
        end
        tmr_pkg::ADDR_HIGH: begin
          v[7:0] = st.high_buf;
        end
        tmr_pkg::ADDR_IRQ_CTRL: begin
          v[tmr_pkg::BIT_IRQ_EN] = st.irq_en;
          v[tmr_pkg::BIT_OVF]    = st.ovf;
        end
        tmr_pkg::ADDR_STATUS: begin
          v[tmr_pkg::ST_W-1:0] = st.status;
        end
        tmr_pkg::ADDR_MASK: begin
          v[tmr_pkg::ST_W-1:0] = st.mask;
        end
        tmr_pkg::ADDR_SLEEP: begin
          v[0] = st.sleep_sw;
        end
        default: begin
          v = 32'h0000_0000;
        end
      endcase
      read_word = v;
    end
  endfunction : read_word

  // s is the next state built so far; cur is the registered state the conditions read
  function automatic state_t apply_write(input state_t s, input state_t cur, input logic [11:0] addr,
                                         input logic [31:0] data);
    state_t n;
    begin
      n = s;
      case (addr)
        tmr_pkg::ADDR_CONTROL: begin
          n.control = data[7:0];
        end
        tmr_pkg::ADDR_LOW: begin
          n.count[7:0] = data[7:0];
          if (!cur.control[tmr_pkg::BIT_WIDTH8]) begin
            n.count[15:8] = cur.high_buf;
          end
          n.inhibit = 2'(tmr_pkg::INHIBIT_CYCLES);
          if (!cur.control[tmr_pkg::BIT_BYPASS]) begin
            n.pre = 8'h00;
          end
        end
        tmr_pkg::ADDR_HIGH: begin
          n.high_buf = data[7:0];
        end
        tmr_pkg::ADDR_IRQ_CTRL: begin
          n.irq_en = data[tmr_pkg::BIT_IRQ_EN];
          n.ovf    = data[tmr_pkg::BIT_OVF];
        end
        tmr_pkg::ADDR_MASK: begin
          n.mask = data[tmr_pkg::ST_W-1:0];
        end
        tmr_pkg::ADDR_SLEEP: begin
          n.sleep_sw = data[0];
        end
        default: begin
          n = s;
        end
      endcase
      apply_write = n;
    end
  endfunction : apply_write

  // reading status clears it; a hardware set applied later still wins
  function automatic state_t apply_read(input state_t s, input state_t cur, input logic [11:0] addr);
    state_t n;
    begin
      n = s;
      if (addr == tmr_pkg::ADDR_STATUS) begin
        n.status = '0;
      end
      if (addr == tmr_pkg::ADDR_LOW && !cur.control[tmr_pkg::BIT_WIDTH8]) begin
        n.high_buf = cur.count[15:8];
      end
      apply_read = n;
    end
  endfunction : apply_read

  // hardware sets come last so they beat a same-cycle clear or flag write
  function automatic state_t apply_wrap(input state_t s, input logic irq_on);
    state_t n;
    begin
      n                         = s;
      n.ovf                     = 1'b1;
      n.status[tmr_pkg::ST_OVF] = 1'b1;
      if (irq_on) begin
        n.status[tmr_pkg::ST_WRAP] = 1'b1;
      end
      apply_wrap = n;
    end
  endfunction : apply_wrap

  // the enable masks the flag path only; the status path has its own mask
  function automatic logic irq_level(input state_t st);
    logic flag_req;
    logic stat_req;
    begin
      flag_req  = st.ovf && st.irq_en;
      stat_req  = |(st.status & st.mask);
      irq_level = flag_req || stat_req;
    end
  endfunction : irq_level

  logic        access;
  logic        wr;
  logic        rd;
  logic        pin_edge;
  logic        event_in;
  logic        tick;
  logic        wrapped;
  logic        run;
  logic [15:0] next_count;
  logic [31:0] rd_val;
  logic        known;
  logic [2:0]  ps_code;
  logic        eight_bit;
  logic        from_pin;
  logic        bypass;
  logic        fall_edge;
  logic        enabled;
  logic        asleep;
  logic        inhibited;

  always_comb begin
    s_d        = s_q;
    access     = psel && penable && !s_q.ready;
    wr         = access && pwrite;
    rd         = access && !pwrite;
    known      = 1'b1;
    rd_val     = 32'h0000_0000;
    tick       = 1'b0;
    wrapped    = 1'b0;
    next_count = s_q.count;

    // first stage only feeds the second
    s_d.pin_s1 = count_pin;
    s_d.pin_s2 = s_q.pin_s1;
    s_d.pin_s3 = s_q.pin_s2;
    // control fields decoded once from the registered copy
    ps_code   = s_q.control[tmr_pkg::PS_LSB +: tmr_pkg::PS_W];
    eight_bit = s_q.control[tmr_pkg::BIT_WIDTH8];
    from_pin  = s_q.control[tmr_pkg::BIT_SRC];
    bypass    = s_q.control[tmr_pkg::BIT_BYPASS];
    fall_edge = s_q.control[tmr_pkg::BIT_EDGE];
    enabled   = s_q.control[tmr_pkg::BIT_ON];
    asleep    = sleep_req || s_q.sleep_sw;
    inhibited = (s_q.inhibit != 2'h0);

    pin_edge = edge_seen(s_q.pin_s3, s_q.pin_s2, fall_edge);
    event_in = from_pin ? pin_edge : 1'b1;
    run      = enabled && !asleep && !inhibited;

    s_d.inhibit = next_inhibit(s_q.inhibit);

    // bypass is sampled live every cycle so reassignment needs no sequence
    if (run && event_in) begin
      if (bypass) begin
        tick = 1'b1;
      end else begin
        s_d.pre = s_q.pre + 8'h01;
        if (prescale_hit(s_q.pre, ps_code)) begin
          tick = 1'b1;
        end
      end
    end

    // tick and wrap are judged on the registered count
    if (tick) begin
      next_count = bump_count(s_q.count, eight_bit);
      wrapped    = wrap_seen(s_q.count, eight_bit);
      s_d.count  = next_count;
    end

    known  = reg_mapped(paddr);
    rd_val = read_word(paddr, s_q);

    // read and write strobes never fall in one cycle
    if (wr) begin
      s_d = apply_write(s_d, s_q, paddr, pwdata);
    end
    if (rd) begin
      s_d = apply_read(s_d, s_q, paddr);
    end

    if (wrapped) begin
      s_d = apply_wrap(s_d, s_q.irq_en);
    end

    s_d.ready = access;
    s_d.err   = access && !known;
    s_d.rdata = (rd && known) ? rd_val : 32'h0000_0000;
    s_d.irq   = irq_level(s_d);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q          <= '0;
      s_q.control  <= tmr_pkg::CONTROL_RESET;
      s_q.high_buf <= tmr_pkg::HIGH_RESET;
      s_q.count    <= {tmr_pkg::HIGH_RESET, tmr_pkg::LOW_RESET};
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata  = s_q.rdata;
  assign pready  = s_q.ready;
  assign pslverr = s_q.err;
  assign irq     = s_q.irq;

endmodule : prescaled_timer

// *** tb/pin_src.sv ***
`timescale 1ns/10ps
module pin_src (
  input wire logic pclk,
  output logic     count_pin
);
  initial count_pin = 1'b0;
  // three cycles per phase outlasts the three-flop synchroniser
  task automatic pulses(input int n);
    repeat (n) begin
      repeat (3) @(posedge pclk);
      count_pin <= 1'b1;
      repeat (3) @(posedge pclk);
      count_pin <= 1'b0;
    end
  endtask : pulses
  task automatic level(input logic v);
    @(posedge pclk);
    count_pin <= v;
  endtask : level
endmodule : pin_src

// *** tb/prescaled_timer_chk.sv ***
`timescale 1ns/10ps
module prescaled_timer_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        count_pin,
  input wire logic        sleep_req,
  input wire logic        irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable && !pready;
  AST_ONE_WAIT: assert property (acc |=> pready) else $error("no ready");
  AST_PULSE: assert property (pready |=> !pready) else $error("ready stuck");
  AST_IDLE_DATA: assert property (!pready |-> prdata == 32'h0) else $error("stray data");
  AST_ERR_RDY: assert property (pslverr |-> pready) else $error("lone error");
  AST_UNMAPPED: assert property (acc && paddr > 12'h018 |=> pslverr && prdata == 32'h0)
    else $error("unmapped accepted");
  AST_HIGH_OK: assert property (acc && paddr == tmr_pkg::ADDR_HIGH |=> !pslverr)
    else $error("buffer refused");
  AST_RDY_CAUSE: assert property (pready |-> $past(psel && penable)) else $error("ready unasked");
  AST_SLEEP_IRQ: assert property ((sleep_req && !psel)[*6] |=> $stable(irq))
    else $error("irq moved asleep");
  COV_IRQ: cover property ($rose(irq));
  COV_ERR: cover property (pslverr);
  COV_LOW_WR: cover property (pready && pwrite && paddr == tmr_pkg::ADDR_LOW);
endmodule : prescaled_timer_chk
bind prescaled_timer prescaled_timer_chk chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .count_pin, .sleep_req, .irq);

// *** tb/prescaled_timer_tb.sv ***
`timescale 1ns/10ps
module prescaled_timer_tb;
  logic        pclk, presetn, psel, penable, pwrite, sleep_req, irq, pready, pslverr, count_pin;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, q2;
  logic        sl;
  int          err_count, n_tests;
  prescaled_timer dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .count_pin, .sleep_req, .irq);
  pin_src src (.pclk, .count_pin);
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic complete_run;
    if (err_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    sl = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rd
  initial begin
    #400000;
    err_count++;
    complete_run;
  end
  initial begin
    {psel, penable, pwrite, sleep_req, presetn} = 5'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(tmr_pkg::ADDR_CONTROL, 32'hff);
    rd(tmr_pkg::ADDR_HIGH, 32'h00);
    chk(sl, 1'b0);
    rd(12'h01c, 32'h0);
    chk(sl, 1'b1);
    wr(tmr_pkg::ADDR_MASK, 32'h0);
    wr(tmr_pkg::ADDR_IRQ_CTRL, 32'h20);
    wr(tmr_pkg::ADDR_CONTROL, 32'h08);
    wr(tmr_pkg::ADDR_HIGH, 32'hff);
    wr(tmr_pkg::ADDR_LOW, 32'hfe);
    rd(tmr_pkg::ADDR_LOW, 32'hfe);
    rd(tmr_pkg::ADDR_HIGH, 32'hff);
    wr(tmr_pkg::ADDR_CONTROL, 32'h88);
    repeat (8) @(posedge pclk);
    chk(irq, 1);
    rd(tmr_pkg::ADDR_IRQ_CTRL, 32'h24);
    rd(tmr_pkg::ADDR_STATUS, 32'h3);
    rd(tmr_pkg::ADDR_STATUS, 32'h0);
    xfer(1'b0, tmr_pkg::ADDR_LOW, 32'h0);
    rd(tmr_pkg::ADDR_HIGH, 32'h00);
    wr(tmr_pkg::ADDR_IRQ_CTRL, 32'h0);
    wr(tmr_pkg::ADDR_LOW, 32'h10);
    rd(tmr_pkg::ADDR_LOW, 32'h11);
    rd(tmr_pkg::ADDR_LOW, 32'h15);
    chk(irq, 0);
    sleep_req <= 1'b1;
    repeat (8) @(posedge pclk);
    xfer(1'b0, tmr_pkg::ADDR_LOW, 32'h0);
    q2 = q;
    xfer(1'b0, tmr_pkg::ADDR_LOW, 32'h0);
    chk(q, q2);
    sleep_req <= 1'b0;
    wr(tmr_pkg::ADDR_CONTROL, 32'h48);
    wr(tmr_pkg::ADDR_LOW, 32'hfd);
    wr(tmr_pkg::ADDR_MASK, 32'h1);
    wr(tmr_pkg::ADDR_CONTROL, 32'hc8);
    repeat (8) @(posedge pclk);
    chk(irq, 1);
    rd(tmr_pkg::ADDR_STATUS, 32'h1);
    wr(tmr_pkg::ADDR_CONTROL, 32'h48);
    chk(irq, 0);
    for (int e = 0; e < 2; e++) begin
      wr(tmr_pkg::ADDR_CONTROL, 32'h68 | (e << 4));
      wr(tmr_pkg::ADDR_LOW, 32'h0);
      wr(tmr_pkg::ADDR_CONTROL, 32'he8 | (e << 4));
      src.level(1'b1);
      repeat (8) @(posedge pclk);
      rd(tmr_pkg::ADDR_LOW, 1 - e);
      src.level(1'b0);
      repeat (8) @(posedge pclk);
      rd(tmr_pkg::ADDR_LOW, 32'h1);
    end
    // odd pulse counts leave a remainder that only the low-byte write can clear
    for (int c = 0; c < 8; c++) begin
      wr(tmr_pkg::ADDR_CONTROL, 32'h60 | c);
      wr(tmr_pkg::ADDR_LOW, 32'h0);
      wr(tmr_pkg::ADDR_CONTROL, 32'he0 | c);
      src.pulses((4 << c) - 1);
      repeat (8) @(posedge pclk);
      rd(tmr_pkg::ADDR_LOW, 32'h1);
    end
    complete_run;
  end
endmodule : prescaled_timer_tb
